// file: hdl/iuv_pkg.sv
// Behaviour
// - Per-page undervoltage fault threshold, readable and writable by the host.
// - Threshold is Linear-11: signed 5-bit exponent high, signed 11-bit mantissa low.
// - Threshold resets to 0000h and loads from the pin strap on strap_load; host writes obey write protection.
// - Threshold and action kept per page; host reaches the selected page.
// - Action is one read/write byte bit field, write protected like threshold.
// - Action byte resets to 80h: shut down, no restart.
// - Fault drives alert low and sets sticky status bit until clear-faults.
// - Action bits 7:6 = 10: disable, then retry per bits 5:3; codes 001-110 leave the output off.
// - Action bits 7:6 = 11: output off while fault present, then resumes.
// - Retry code 000: no restart, output off until fault cleared.
// - Retry code 111: restart continuously until off, bias loss or other fault.
// - Interval between restart attempts counts in 70 ms units.
// - Fault clears only once input rises above the warning threshold.
`default_nettype none
package iuv_pkg;
    // ============================================================
    // Command codes and layout
    localparam logic [7:0]  IUV_CMD_THRESHOLD  = 8'h59;
    localparam logic [7:0]  IUV_CMD_ACTION     = 8'h5a;
    localparam logic [7:0]  IUV_ACTION_RESET   = 8'h80;
    localparam logic [15:0] IUV_THR_RESET      = 16'h0000;
    localparam logic [31:0] IUV_CNT_RESET      = 32'h00000000;
    localparam int          IUV_PAGES          = 2;
    localparam int          IUV_EXP_MSB        = 15;
    localparam int          IUV_EXP_LSB        = 11;
    localparam int          IUV_MODE_MSB       = 7;
    localparam int          IUV_MODE_LSB       = 6;
    localparam int          IUV_RETRY_MSB      = 5;
    localparam int          IUV_RETRY_LSB      = 3;
    localparam logic [1:0]  IUV_MODE_RETRY     = 2'h2;
    localparam logic [1:0]  IUV_MODE_WHILE     = 2'h3;
    localparam logic [2:0]  IUV_RETRY_NONE     = 3'h0;
    localparam logic [2:0]  IUV_RETRY_FOREVER  = 3'h7;
    // ============================================================
    // Timing
    localparam int          IUV_CLK_MHZ        = 250;
    localparam int          IUV_RETRY_MS       = 70;
    localparam int          IUV_RETRY_CYCLES   = IUV_RETRY_MS * 1000 * IUV_CLK_MHZ;
    localparam int          IUV_FRAC           = 16;
    typedef enum logic [1:0] {IUV_RUN, IUV_OFF, IUV_WAIT} iuv_state_t;
endpackage : iuv_pkg
`default_nettype wire

// file: hdl/iuv_fault_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module iuv_fault_ctrl #(
    parameter int RETRY_CYCLES = iuv_pkg::IUV_RETRY_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        page_sel,
    input  wire logic        cmd_wr,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic        write_protect,
    input  wire logic        clear_faults,
    input  wire logic        strap_load,
    input  wire logic [15:0] strap_threshold,
    input  wire logic [15:0] warn_threshold,
    input  wire logic        meas_valid,
    input  wire logic [15:0] meas_vin,
    input  wire logic        output_cmd_on,
    input  wire logic        bias_ok,
    input  wire logic        other_fault,
    output logic      [15:0] cmd_rdata,
    output logic             alert_out_n,
    output logic [1:0]       status_fault,
    output logic [1:0]       output_enable
);
    import iuv_pkg::*;

    // ============================================================
    // Command decode
    wire logic wr_ok      = cmd_wr && !write_protect;
    wire logic wr_thr     = wr_ok && (cmd_code == IUV_CMD_THRESHOLD);
    wire logic wr_act     = wr_ok && (cmd_code == IUV_CMD_ACTION);

    logic [15:0] thr_q [IUV_PAGES];
    logic [7:0]  act_q [IUV_PAGES];

    // ============================================================
    // Read path
    // Value 1 of the page index selects the second copy
    wire logic [15:0] rd_mux = (cmd_code == IUV_CMD_THRESHOLD) ? thr_q[page_sel] :
                               (cmd_code == IUV_CMD_ACTION) ? {8'h00, act_q[page_sel]} : 16'h0000;

    // ============================================================
    // Linear-11 decode
    // Linear-11 to unsigned volts with IUV_FRAC fractional bits.
    // Negative mantissas clamp to zero. Large exponents shift bits out
    // of the top; thresholds inside 0-19 V never get that far.
    function automatic logic [31:0] lin11(input logic [15:0] w);
        logic signed [4:0]  n;
        logic signed [10:0] y;
        logic [31:0]        m;
        int                 sh;
        n = w[IUV_EXP_MSB:IUV_EXP_LSB];
        y = w[IUV_EXP_LSB-1:0];
        m = y[10] ? 32'h0 : {21'h0, y};
        sh = IUV_FRAC + n;
        if (sh >= 0) lin11 = m << sh;
        else lin11 = m >> (-sh);
    endfunction : lin11

    // ============================================================
    // Per-page state
    logic        flt_q   [IUV_PAGES];
    logic        stat_q  [IUV_PAGES];
    logic        en_q    [IUV_PAGES];
    logic [31:0] cnt_q   [IUV_PAGES];
    iuv_state_t  st_q    [IUV_PAGES];

    // Shared by both pages: one input rail, one warning point
    // Measurement arrives already in whole volts
    wire logic [31:0] meas_volts = {16'h0000, meas_vin};
    wire logic [31:0] warn_volts = lin11(warn_threshold) >> IUV_FRAC;
    // Levels sampled every cycle; a stop holds the retry counter and blocks the restart, even once the count is done
    wire logic        stop_retry = !output_cmd_on || !bias_ok || other_fault;

    genvar g;
    generate
        for (g = 0; g < IUV_PAGES; g++) begin : g_page
            // ============================================================
            // Field decode
            wire logic        sel        = (page_sel == 1'(g));
            wire logic [1:0]  mode       = act_q[g][IUV_MODE_MSB:IUV_MODE_LSB];
            wire logic [2:0]  retry      = act_q[g][IUV_RETRY_MSB:IUV_RETRY_LSB];
            wire logic [31:0] flt_volts  = lin11(thr_q[g]) >> IUV_FRAC;
            wire logic        act_mode   = (mode == IUV_MODE_RETRY) || (mode == IUV_MODE_WHILE);
            wire logic        mode_while = (mode == IUV_MODE_WHILE);
            wire logic        retry_ever = (retry == IUV_RETRY_FOREVER);
            wire logic        retry_none = (retry == IUV_RETRY_NONE);

            // ============================================================
            // Fault detection
            // Whole volts only: a fractional threshold is rounded down
            wire logic        below_flt  = meas_valid && (meas_volts < flt_volts);
            wire logic        above_warn = meas_valid && (meas_volts > warn_volts);
            wire logic        fault_new  = below_flt && !flt_q[g];
            // In modes 10 and 11 every low reading trips a running output, so a retry that
            // lands in a standing fault is shut down again
            wire logic        trip       = below_flt && act_mode;

            // ============================================================
            // Restart conditions
            wire logic        cnt_done   = (cnt_q[g] >= 32'(RETRY_CYCLES - 1));
            wire logic        retry_run  = retry_ever && !stop_retry;
            wire logic        clr_run    = retry_none && clear_faults && !flt_q[g];
            wire logic        gone_run   = !flt_q[g];

            // ============================================================
            // Register next values
            // Strap load beats a host write in the same cycle
            wire logic [15:0] thr_d      = strap_load ? strap_threshold :
                                           (wr_thr && sel) ? cmd_wdata : thr_q[g];
            wire logic [7:0]  act_d      = (wr_act && sel) ? cmd_wdata[7:0] : act_q[g];
            wire logic        flt_d      = below_flt ? 1'b1 : (above_warn ? 1'b0 : flt_q[g]);
            // Set wins over a clear that lands in the same cycle
            wire logic        stat_d     = fault_new ? 1'b1 : (clear_faults ? 1'b0 : stat_q[g]);

            iuv_state_t       st_d;
            logic             en_d;
            logic [31:0]      cnt_d;

            always_comb begin
                st_d  = st_q[g];
                en_d  = en_q[g];
                cnt_d = cnt_q[g];
                case (st_q[g])
                    IUV_RUN: begin
                        en_d = 1'b1;
                        if (trip) begin
                            en_d  = 1'b0;
                            cnt_d = IUV_CNT_RESET;
                            st_d  = mode_while ? IUV_WAIT : IUV_OFF;
                        end
                    end
                    IUV_OFF: begin
                        // Frozen clock enable stretches the interval with it
                        if (retry_run) begin
                            if (cnt_done) begin
                                st_d = IUV_RUN;
                                en_d = 1'b1;
                            end else begin
                                cnt_d = cnt_q[g] + 32'h00000001;
                            end
                        end else if (clr_run) begin
                            st_d = IUV_RUN;
                            en_d = 1'b1;
                        end
                    end
                    IUV_WAIT: begin
                        if (gone_run) begin
                            st_d = IUV_RUN;
                            en_d = 1'b1;
                        end
                    end
                    default: begin
                        st_d = IUV_RUN;
                        en_d = 1'b1;
                    end
                endcase
            end

            // Host-visible settings
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    thr_q[g] <= IUV_THR_RESET;
                    act_q[g] <= IUV_ACTION_RESET;
                end else if (clk_en) begin
                    thr_q[g] <= thr_d;
                    act_q[g] <= act_d;
                end
            end

            // Outputs come up enabled; only a fault takes them away
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    flt_q[g]  <= 1'b0;
                    stat_q[g] <= 1'b0;
                    en_q[g]   <= 1'b1;
                    cnt_q[g]  <= IUV_CNT_RESET;
                    st_q[g]   <= IUV_RUN;
                end else if (clk_en) begin
                    flt_q[g]  <= flt_d;
                    stat_q[g] <= stat_d;
                    en_q[g]   <= en_d;
                    cnt_q[g]  <= cnt_d;
                    st_q[g]   <= st_d;
                end
            end
        end
    endgenerate

    // ============================================================
    // Output next values
    // Alert is the OR of both pages' sticky bits, so it stays low
    // until the host clears every page
    wire logic        alert_n_d = !(stat_q[0] || stat_q[1]);
    wire logic [1:0]  status_d  = {stat_q[1], stat_q[0]};
    wire logic [1:0]  enable_d  = {en_q[1], en_q[0]};

    // ============================================================
    // Output registers
    // Registered so every pin leaves a flip-flop
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_rdata     <= 16'h0000;
            alert_out_n   <= 1'b1;
            status_fault  <= 2'h0;
            output_enable <= 2'h3;
        end else if (clk_en) begin
            cmd_rdata     <= rd_mux;
            alert_out_n   <= alert_n_d;
            status_fault  <= status_d;
            output_enable <= enable_d;
        end
    end
endmodule : iuv_fault_ctrl
`default_nettype wire

// file: verif/iuv_fault_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module iuv_fault_ctrl_chk
    import iuv_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        cmd_wr,
    input wire logic        page_sel,
    input wire logic        write_protect,
    input wire logic        strap_load,
    input wire logic        clear_faults,
    input wire logic        meas_valid,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] cmd_rdata,
    input wire logic        alert_out_n,
    input wire logic [1:0]  status_fault,
    input wire logic [1:0]  output_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ============================================================
    // Checks
    AST_ALERT_LOW: assert property (|status_fault |-> !alert_out_n) else $error("alert idle");
    AST_ALERT_HIGH: assert property (status_fault == 2'h0 |-> alert_out_n) else $error("alert low");
    // Status output trails the sticky bit by one register stage
    AST_STICKY: assert property (clk_en && !clear_faults ##1 status_fault[0] |=> status_fault[0])
        else $error("status dropped");
    AST_CLEAR: assert property (clk_en && clear_faults && !meas_valid ##1 clk_en |=> status_fault == 2'h0)
        else $error("status kept");
    AST_RISE: assert property ($rose(status_fault[0]) |-> $past(meas_valid, 2) || !$past(clk_en) || !$past(clk_en, 2))
        else $error("status no cause");
    AST_UNK: assert property (clk_en && cmd_code != IUV_CMD_THRESHOLD && cmd_code != IUV_CMD_ACTION
        |=> cmd_rdata == 16'h0000) else $error("unknown code data");
    AST_ACT_HI: assert property (clk_en && cmd_code == IUV_CMD_ACTION |=> cmd_rdata[15:8] == 8'h00)
        else $error("action upper byte");
    // Protected writes must leave the read value alone
    AST_WP: assert property (clk_en && write_protect && !strap_load ##1 $stable(cmd_code) && $stable(page_sel)
        |=> $stable(cmd_rdata)) else $error("write while protected");
    cover property (!alert_out_n);
    cover property ($rose(output_enable[0]));
    cover property (clk_en && cmd_wr && write_protect);
    cover property (output_enable == 2'h0);
endmodule : iuv_fault_ctrl_chk
`default_nettype wire

// file: verif/iuv_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module iuv_host_model (
    input  wire logic        clock,
    input  wire logic [15:0] cmd_rdata,
    output logic             cmd_wr,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    output logic             page_sel
);
    initial begin
        {cmd_wr, cmd_code, cmd_wdata, page_sel} = '0;
    end
    // Whole Linear-11 word per write; data scrambled once released
    task automatic wr(input logic pg, input logic [7:0] c, input logic [15:0] d);
        @(posedge clock) #1 {page_sel, cmd_code, cmd_wdata, cmd_wr} = {pg, c, d, 1'b1};
        @(posedge clock) #1 {cmd_wr, cmd_wdata} = {1'b0, ~d};
    endtask : wr
    task automatic rd(input logic pg, input logic [7:0] c, output logic [15:0] d);
        @(posedge clock) #1 {page_sel, cmd_code} = {pg, c};
        repeat (2) @(posedge clock);
        #1 d = cmd_rdata;
    endtask : rd
endmodule : iuv_host_model
`default_nettype wire

// file: verif/test_input_undervolt_fault_control.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; $display("ERROR %0t: %h not %h", $time, a, e); end end
module test_input_undervolt_fault_control;
    import iuv_pkg::*;
    localparam int RC = 20;
    logic        clock, rst_n, clk_en, cmd_wr, write_protect, clear_faults, strap_load, meas_valid, page_sel;
    logic        output_cmd_on, bias_ok, other_fault, alert_out_n;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, strap_threshold, warn_threshold, meas_vin, cmd_rdata, rd;
    logic [1:0]  status_fault, output_enable;
    int          bad_count = 0, cmp_count = 0;
    iuv_fault_ctrl #(.RETRY_CYCLES(RC)) dut (
        .clock           (clock),
        .rst_n           (rst_n),
        .clk_en          (clk_en),
        .page_sel        (page_sel),
        .cmd_wr          (cmd_wr),
        .cmd_code        (cmd_code),
        .cmd_wdata       (cmd_wdata),
        .write_protect   (write_protect),
        .clear_faults    (clear_faults),
        .strap_load      (strap_load),
        .strap_threshold (strap_threshold),
        .warn_threshold  (warn_threshold),
        .meas_valid      (meas_valid),
        .meas_vin        (meas_vin),
        .output_cmd_on   (output_cmd_on),
        .bias_ok         (bias_ok),
        .other_fault     (other_fault),
        .cmd_rdata       (cmd_rdata),
        .alert_out_n     (alert_out_n),
        .status_fault    (status_fault),
        .output_enable   (output_enable)
    );
    iuv_host_model host (
        .clock     (clock),
        .cmd_rdata (cmd_rdata),
        .cmd_wr    (cmd_wr),
        .cmd_code  (cmd_code),
        .cmd_wdata (cmd_wdata),
        .page_sel  (page_sel)
    );
    task automatic pulse(ref logic s);
        @(posedge clock) #1 s = 1'b1;
        @(posedge clock) #1 s = 1'b0;
    endtask : pulse
    task automatic meas(input logic [15:0] v);
        meas_vin = v;
        pulse(meas_valid);
        repeat (3) @(posedge clock);
        #1;
    endtask : meas
    task print_verdict;
        $display("TB: %0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        #20000 bad_count++;
        print_verdict;
    end
    initial begin
        {rst_n, write_protect, clear_faults, strap_load, meas_valid, other_fault} = '0;
        {clk_en, output_cmd_on, bias_ok} = 3'h7;
        {meas_vin, strap_threshold, warn_threshold} = {16'h0010, 16'h000a, 16'h000c};
        repeat (4) @(posedge clock);
        #1 rst_n = 1'b1;
        pulse(strap_load);
        host.rd(1, IUV_CMD_THRESHOLD, rd); `CHK(rd, 16'h000a)
        host.rd(1, IUV_CMD_ACTION, rd); `CHK(rd, 16'h0080)
        host.wr(0, IUV_CMD_ACTION, 16'h00c0);
        host.wr(1, IUV_CMD_THRESHOLD, 16'h000b);
        write_protect = 1'b1;
        host.wr(0, IUV_CMD_ACTION, 16'h0090);
        write_protect = 1'b0;
        host.rd(0, IUV_CMD_ACTION, rd); `CHK(rd, 16'h00c0)
        host.rd(1, IUV_CMD_THRESHOLD, rd); `CHK(rd, 16'h000b)
        host.rd(0, IUV_CMD_THRESHOLD, rd); `CHK(rd, 16'h000a)
        host.rd(0, 8'h5b, rd); `CHK(rd, 16'h0000)
        clk_en = 1'b0;
        host.wr(0, IUV_CMD_ACTION, 16'h0080);
        clk_en = 1'b1;
        host.rd(0, IUV_CMD_ACTION, rd); `CHK(rd, 16'h00c0)
        $display("TB: register test done");
        meas(16'h0009); `CHK({alert_out_n, status_fault, output_enable}, 5'h0c)
        meas(16'h000b); `CHK(output_enable, 2'h0)
        meas(16'h000d); `CHK({status_fault, output_enable}, 4'hd)
        pulse(clear_faults);
        repeat (2) @(posedge clock);
        #1 `CHK({alert_out_n, status_fault, output_enable}, 5'h13)
        host.wr(1, IUV_CMD_ACTION, 16'h00b8);
        meas(16'h0009); `CHK(output_enable, 2'h0)
        repeat (RC - 3) @(posedge clock);
        #1 `CHK(output_enable, 2'h0)
        @(posedge clock);
        #1 `CHK(output_enable, 2'h2)
        bias_ok = 1'b0;
        meas(16'h0009);
        repeat (RC + 10) @(posedge clock);
        #1 `CHK(output_enable[1], 1'b0)
        $display("TB: fault test done");
        print_verdict;
    end
endmodule : test_input_undervolt_fault_control
bind iuv_fault_ctrl iuv_fault_ctrl_chk u_chk (
    .clock         (clock),
    .rst_n         (rst_n),
    .clk_en        (clk_en),
    .cmd_wr        (cmd_wr),
    .page_sel      (page_sel),
    .write_protect (write_protect),
    .strap_load    (strap_load),
    .clear_faults  (clear_faults),
    .meas_valid    (meas_valid),
    .cmd_code      (cmd_code),
    .cmd_rdata     (cmd_rdata),
    .alert_out_n   (alert_out_n),
    .status_fault  (status_fault),
    .output_enable (output_enable)
);
`default_nettype wire
